/* sio_pkg.sv */
// package for the clock-synchronous serial shift block: offsets, fields, codes
// assumes a 32-bit register port with byte addresses on word boundaries
`default_nettype none

package sio_pkg;

    // register byte addresses
    localparam logic [7:0] OFF_ENABLE  = 8'h00;
    localparam logic [7:0] OFF_XFER    = 8'h04;
    localparam logic [7:0] OFF_DATA    = 8'h08;
    localparam logic [7:0] OFF_MODE    = 8'h0c; // write: mode control, read: status
    localparam logic [7:0] OFF_IRQ_ST  = 8'h10;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h14;

    // field positions
    localparam int EN_BIT     = 7;
    localparam int START_BIT  = 7;
    localparam int INH_BIT    = 6;
    localparam int DIR_LSB    = 4;
    localparam int XFER_ONE   = 3;
    localparam int SCK_LSB    = 0;
    localparam int MODE_LSB   = 2;
    localparam int ST_XFER    = 3;
    localparam int ST_SHIFT   = 2;
    localparam int IRQ_EMPTY  = 0;
    localparam int IRQ_RXDONE = 1;
    localparam int IRQ_W      = 2;

    // fixed read patterns
    localparam logic [7:0] STATUS_ONES = 8'hf3;

    // transfer direction codes
    localparam logic [1:0] DIR_TX  = 2'h0;
    localparam logic [1:0] DIR_TRX = 2'h2;
    localparam logic [1:0] DIR_RX  = 2'h3;

    // interface mode codes
    localparam logic [1:0] MODE_PORT = 2'h0;
    localparam logic [1:0] MODE_SIO  = 2'h1;
    localparam logic [1:0] MODE_BUS  = 2'h2;

    // serial clock selection
    localparam logic [2:0] SCK_EXT = 3'h7;
    localparam int         DIV_W   = 8;
    // extra system clocks per half period so synchronised data-in settles before sampling
    localparam logic [DIV_W-1:0] SAMPLE_SLACK = 8'h04;

    // reset values
    localparam logic [1:0] DIR_RST  = 2'h0;
    localparam logic [2:0] SCK_RST  = 3'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // index of the last bit in one frame
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_LOAD  = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_WAIT  = 4'b1000
    } xfer_state_e;

endpackage : sio_pkg

`default_nettype wire

/* sck_rate_divider.sv */
// serial clock rate divider: one-cycle tick every 2^(sel+1) plus slack system clocks
// assumes the caller gates run low whenever no internal serial clock is wanted
`default_nettype none
`timescale 1ns/1ps

module sck_rate_divider (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     run,
    input  wire logic [2:0]               sel,
    output logic                          tick
);
    logic [sio_pkg::DIV_W-1:0] cnt_ff;
    logic [sio_pkg::DIV_W-1:0] nxt_cnt;
    logic [sio_pkg::DIV_W-1:0] limit;
    logic                      tick_ff;
    logic                      nxt_tick;

    // half period limit; the counter restarts whenever run drops
    // slack keeps the fastest rates slower than the data-in synchroniser lag
    always_comb begin
        limit    = sio_pkg::DIV_W'((1 << (sel + 3'h1)) - 1) + sio_pkg::SAMPLE_SLACK;
        nxt_tick = 1'b0;
        nxt_cnt  = '0;
        if (run) begin
            if (cnt_ff >= limit) begin
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + sio_pkg::DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule : sck_rate_divider

`default_nettype wire

/* sync_serial_sio.sv */
// clock-synchronous 8-bit serial shift interface with its register port
// assumes a single-cycle register master on CLK and a shift partner on pins
`default_nettype none
`timescale 1ns/1ps

module sync_serial_sio (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        SCK_I,
    output logic             SCK_O,
    output logic             SCK_OE,
    output logic             SO,
    input  wire logic        SI,
    output logic             IRQ
);
    // pin synchronisers, three stages each
    logic [2:0] sck_sync_ff;
    logic [2:0] si_sync_ff;
    logic       sck_pin_ff;
    logic       si_pin_ff;

    // registers and engine state
    logic                     en_ff,       nxt_en;
    logic                     start_ff,    nxt_start;
    logic                     inh_ff,      nxt_inh;
    logic [1:0]               dir_ff,      nxt_dir;
    logic [2:0]               sck_sel_ff,  nxt_sck_sel;
    logic [1:0]               mode_ff,     nxt_mode;
    logic [7:0]               tx_buf_ff,   nxt_tx_buf;
    logic                     tx_full_ff,  nxt_tx_full;
    logic [7:0]               rx_buf_ff,   nxt_rx_buf;
    logic [7:0]               shreg_ff,    nxt_shreg;
    logic [2:0]               bit_cnt_ff,  nxt_bit_cnt;
    logic [sio_pkg::IRQ_W-1:0] isr_ff,     nxt_isr;
    logic [sio_pkg::IRQ_W-1:0] imr_ff,     nxt_imr;
    sio_pkg::xfer_state_e     state_ff,    nxt_state;
    logic                     sck_ff,      nxt_sck;
    logic                     sck_oe_ff,   nxt_sck_oe;
    logic                     so_ff,       nxt_so;
    logic                     irq_ff,      nxt_irq;
    logic [31:0]              rdata_ff,    nxt_rdata;

    logic                     ext_clk;
    logic                     div_tick;
    logic                     lead_edge;
    logic                     trail_edge;
    logic [sio_pkg::IRQ_W-1:0] events;
    logic [7:0]               shifted;

    // pins change only once the second and third stages agree
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sck_sync_ff <= 3'h7;
            si_sync_ff  <= 3'h0;
            sck_pin_ff  <= 1'b1;
            si_pin_ff   <= 1'b0;
        end else begin
            sck_sync_ff <= {sck_sync_ff[1:0], SCK_I};
            si_sync_ff  <= {si_sync_ff[1:0], SI};
            if (sck_sync_ff[1] == sck_sync_ff[2]) begin
                sck_pin_ff <= sck_sync_ff[2];
            end
            if (si_sync_ff[1] == si_sync_ff[2]) begin
                si_pin_ff <= si_sync_ff[2];
            end
        end
    end

    assign ext_clk = (sck_sel_ff == sio_pkg::SCK_EXT);

    // internal rate divider, runs only while shifting
    sck_rate_divider u_div (
        .clk  (CLK),
        .rst  (RST),
        .run  (en_ff && !ext_clk && (state_ff == sio_pkg::ST_RUN)),
        .sel  (sck_sel_ff),
        .tick (div_tick)
    );

    // leading edge drives data out, trailing edge samples it in
    always_comb begin
        if (ext_clk) begin
            lead_edge  = (sck_sync_ff[1] == sck_sync_ff[2]) && !sck_sync_ff[2] && sck_pin_ff;
            trail_edge = (sck_sync_ff[1] == sck_sync_ff[2]) && sck_sync_ff[2] && !sck_pin_ff;
        end else begin
            lead_edge  = div_tick && sck_ff;
            trail_edge = div_tick && !sck_ff;
        end
    end

    // bits enter at the top so the byte ends aligned at bit 0
    assign shifted = {si_pin_ff, shreg_ff[7:1]};

    // register port, shift engine and interrupt status
    always_comb begin
        nxt_en      = en_ff;
        nxt_start   = start_ff;
        nxt_inh     = inh_ff;
        nxt_dir     = dir_ff;
        nxt_sck_sel = sck_sel_ff;
        nxt_mode    = mode_ff;
        nxt_tx_buf  = tx_buf_ff;
        nxt_tx_full = tx_full_ff;
        nxt_rx_buf  = rx_buf_ff;
        nxt_shreg   = shreg_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_imr     = imr_ff;
        nxt_state   = state_ff;
        nxt_sck     = sck_ff;
        nxt_so      = so_ff;
        nxt_rdata   = 32'h0;
        events      = '0;

        // engine steps only while the interface is enabled
        if (en_ff) begin
            unique case (state_ff)
                sio_pkg::ST_IDLE: begin
                    // start waits for data unless receive only
                    if (start_ff && !inh_ff &&
                        (dir_ff == sio_pkg::DIR_RX || tx_full_ff)) begin
                        nxt_state = sio_pkg::ST_LOAD;
                    end
                end
                sio_pkg::ST_LOAD: begin
                    // move buffer to shifter, flag it empty
                    if (dir_ff != sio_pkg::DIR_RX) begin
                        nxt_shreg          = tx_buf_ff;
                        nxt_tx_full        = 1'b0;
                        events[sio_pkg::IRQ_EMPTY] = 1'b1;
                    end
                    nxt_bit_cnt = '0;
                    nxt_sck     = 1'b1;
                    nxt_state   = sio_pkg::ST_RUN;
                end
                sio_pkg::ST_RUN: begin
                    if (lead_edge) begin
                        nxt_sck = 1'b0;
                        // receive only leaves the output line alone
                        if (dir_ff != sio_pkg::DIR_RX) begin
                            nxt_so = shreg_ff[0];
                        end
                    end else if (trail_edge) begin
                        nxt_sck     = 1'b1;
                        nxt_shreg   = shifted;
                        nxt_bit_cnt = bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == sio_pkg::LAST_BIT) begin
                            if (dir_ff != sio_pkg::DIR_TX) begin
                                nxt_rx_buf = shifted;
                                events[sio_pkg::IRQ_RXDONE] = 1'b1;
                            end
                            // a stop request ends after the current byte
                            if (!start_ff) begin
                                nxt_state = sio_pkg::ST_IDLE;
                            end else if (dir_ff != sio_pkg::DIR_RX && !tx_full_ff) begin
                                nxt_state = sio_pkg::ST_WAIT;
                            end else begin
                                nxt_state = sio_pkg::ST_LOAD;
                            end
                        end
                    end
                end
                sio_pkg::ST_WAIT: begin
                    // clock held until software refills the buffer
                    if (!start_ff) begin
                        nxt_state = sio_pkg::ST_IDLE;
                    end else if (tx_full_ff) begin
                        nxt_state = sio_pkg::ST_LOAD;
                    end
                end
            endcase
            // inhibit aborts immediately and drops the start request
            if (inh_ff && state_ff != sio_pkg::ST_IDLE) begin
                nxt_state = sio_pkg::ST_IDLE;
                nxt_start = 1'b0;
                nxt_sck   = 1'b1;
            end
        end

        // register writes; writes other than enable need the enable bit set
        if (WR) begin
            if (ADDR == sio_pkg::OFF_ENABLE) begin
                nxt_en = WDATA[sio_pkg::EN_BIT];
            end else if (en_ff) begin
                unique case (ADDR)
                    sio_pkg::OFF_XFER: begin
                        nxt_start   = WDATA[sio_pkg::START_BIT];
                        nxt_inh     = WDATA[sio_pkg::INH_BIT];
                        nxt_dir     = WDATA[sio_pkg::DIR_LSB +: 2];
                        nxt_sck_sel = WDATA[sio_pkg::SCK_LSB +: 3];
                    end
                    sio_pkg::OFF_DATA: begin
                        // write side only; reads see the receive byte
                        nxt_tx_buf  = WDATA[7:0];
                        nxt_tx_full = 1'b1;
                    end
                    sio_pkg::OFF_MODE: begin
                        nxt_mode = WDATA[sio_pkg::MODE_LSB +: 2];
                    end
                    sio_pkg::OFF_IRQ_MSK: begin
                        nxt_imr = WDATA[sio_pkg::IRQ_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // reads answer in the next cycle; fixed bits, unmapped reads zero
        if (RD) begin
            unique case (ADDR)
                sio_pkg::OFF_ENABLE: begin
                    nxt_rdata[sio_pkg::EN_BIT] = en_ff;
                end
                sio_pkg::OFF_XFER: begin
                    nxt_rdata[sio_pkg::START_BIT]       = start_ff;
                    nxt_rdata[sio_pkg::INH_BIT]         = inh_ff;
                    nxt_rdata[sio_pkg::DIR_LSB +: 2]    = dir_ff;
                    nxt_rdata[sio_pkg::XFER_ONE]        = 1'b1;
                    nxt_rdata[sio_pkg::SCK_LSB +: 3]    = sck_sel_ff;
                    // low clock bit reads one unless shift mode is chosen
                    if (mode_ff != sio_pkg::MODE_SIO) begin
                        nxt_rdata[sio_pkg::SCK_LSB] = 1'b1;
                    end
                end
                sio_pkg::OFF_DATA: begin
                    nxt_rdata[7:0] = rx_buf_ff;
                end
                sio_pkg::OFF_MODE: begin
                    // status view of the shared address
                    nxt_rdata[7:0]               = sio_pkg::STATUS_ONES;
                    nxt_rdata[sio_pkg::ST_XFER]  = (state_ff != sio_pkg::ST_IDLE);
                    nxt_rdata[sio_pkg::ST_SHIFT] = (state_ff == sio_pkg::ST_RUN);
                end
                sio_pkg::OFF_IRQ_ST: begin
                    nxt_rdata[sio_pkg::IRQ_W-1:0] = isr_ff;
                end
                sio_pkg::OFF_IRQ_MSK: begin
                    nxt_rdata[sio_pkg::IRQ_W-1:0] = imr_ff;
                end
                default: begin
                end
            endcase
        end

        // sticky status: a read clears, a new event in that cycle still sets
        nxt_isr    = ((RD && ADDR == sio_pkg::OFF_IRQ_ST) ? '0 : isr_ff) | events;
        nxt_irq    = |(nxt_isr & nxt_imr);
        // the pin is driven only with an internal clock mid transfer
        nxt_sck_oe = (nxt_sck_sel != sio_pkg::SCK_EXT) && (nxt_state != sio_pkg::ST_IDLE);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            en_ff      <= 1'b0;
            start_ff   <= 1'b0;
            inh_ff     <= 1'b0;
            dir_ff     <= sio_pkg::DIR_RST;
            sck_sel_ff <= sio_pkg::SCK_RST;
            mode_ff    <= sio_pkg::MODE_RST;
            tx_buf_ff  <= sio_pkg::BYTE_RST;
            tx_full_ff <= 1'b0;
            rx_buf_ff  <= sio_pkg::BYTE_RST;
            shreg_ff   <= sio_pkg::BYTE_RST;
            bit_cnt_ff <= '0;
            isr_ff     <= '0;
            imr_ff     <= '0;
            state_ff   <= sio_pkg::ST_IDLE;
            sck_ff     <= 1'b1;
            sck_oe_ff  <= 1'b0;
            so_ff      <= 1'b0;
            irq_ff     <= 1'b0;
            rdata_ff   <= 32'h0;
        end else begin
            en_ff      <= nxt_en;
            start_ff   <= nxt_start;
            inh_ff     <= nxt_inh;
            dir_ff     <= nxt_dir;
            sck_sel_ff <= nxt_sck_sel;
            mode_ff    <= nxt_mode;
            tx_buf_ff  <= nxt_tx_buf;
            tx_full_ff <= nxt_tx_full;
            rx_buf_ff  <= nxt_rx_buf;
            shreg_ff   <= nxt_shreg;
            bit_cnt_ff <= nxt_bit_cnt;
            isr_ff     <= nxt_isr;
            imr_ff     <= nxt_imr;
            state_ff   <= nxt_state;
            sck_ff     <= nxt_sck;
            sck_oe_ff  <= nxt_sck_oe;
            so_ff      <= nxt_so;
            irq_ff     <= nxt_irq;
            rdata_ff   <= nxt_rdata;
        end
    end

    assign RDATA  = rdata_ff;
    assign SCK_O  = sck_ff;
    assign SCK_OE = sck_oe_ff;
    assign SO     = so_ff;
    assign IRQ    = irq_ff;

    // checks on the engine and the register port
    enable_freeze_a: assert property (@(posedge CLK) disable iff (RST)
        !en_ff |=> $stable(state_ff))
        else $error("engine moved while disabled");

    disable_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (!en_ff && !(WR && ADDR == sio_pkg::OFF_ENABLE)) |=>
            $stable(dir_ff) && $stable(sck_sel_ff) && $stable(mode_ff))
        else $error("setting changed while disabled");

    start_load_a: assert property (@(posedge CLK) disable iff (RST)
        (en_ff && state_ff == sio_pkg::ST_IDLE && start_ff && !inh_ff && tx_full_ff)
            |=> state_ff == sio_pkg::ST_LOAD ##1 state_ff == sio_pkg::ST_RUN)
        else $error("start did not begin a transfer");

    inhibit_abort_a: assert property (@(posedge CLK) disable iff (RST)
        (en_ff && inh_ff && state_ff != sio_pkg::ST_IDLE) |=>
            state_ff == sio_pkg::ST_IDLE && !start_ff)
        else $error("inhibit did not abort");

    rx_keep_a: assert property (@(posedge CLK) disable iff (RST)
        (state_ff == sio_pkg::ST_LOAD && dir_ff == sio_pkg::DIR_RX && en_ff &&
            !(WR && ADDR == sio_pkg::OFF_DATA)) |=> $stable(tx_full_ff))
        else $error("receive only consumed the write buffer");

    sck_low_read_a: assert property (@(posedge CLK) disable iff (RST)
        (RD && ADDR == sio_pkg::OFF_XFER && mode_ff != sio_pkg::MODE_SIO) |=> RDATA[0])
        else $error("clock field low bit not one");

    status_view_a: assert property (@(posedge CLK) disable iff (RST)
        (RD && ADDR == sio_pkg::OFF_MODE) |=>
            RDATA[sio_pkg::ST_XFER] == $past(state_ff != sio_pkg::ST_IDLE) &&
            RDATA[7:4] == 4'hf)
        else $error("status read wrong");

    empty_flag_a: assert property (@(posedge CLK) disable iff (RST)
        (en_ff && state_ff == sio_pkg::ST_LOAD && dir_ff != sio_pkg::DIR_RX) |=>
            isr_ff[sio_pkg::IRQ_EMPTY])
        else $error("buffer empty event missing");

    ext_release_a: assert property (@(posedge CLK) disable iff (RST)
        ext_clk && !(WR && ADDR == sio_pkg::OFF_XFER) |=> !SCK_OE)
        else $error("clock pin driven in external mode");

endmodule : sync_serial_sio

`default_nettype wire

/* shift_partner.sv */
// far-side shift device: catches SO on rising serial clock, drives SI on falling
// assumes the bench resolves the clock pin; external frames are 8 clocks of 160 ns
`default_nettype none
`timescale 1ns/1ps

module shift_partner (
    input  wire logic       sck,
    input  wire logic       so,
    input  wire logic       ext_go,
    input  wire logic [7:0] tx_byte,
    output logic            si,
    output logic            sck_ext,
    output logic      [7:0] rx_byte
);
    logic [2:0] cnt;

    // counter cleared after time zero so the power-up edge on the pin is not a bit
    initial begin
        si = 1'b0;
        sck_ext = 1'b1;
        rx_byte = 8'h00;
        #1 cnt = 3'h0;
    end

    // LSB first, caught on rising edge
    always @(posedge sck) begin
        rx_byte <= {so, rx_byte[7:1]};
        cnt <= cnt + 3'h1;
        if (cnt == 3'h7) begin
            si <= ~si; // after the frame the line holds no stale bit
        end
    end

    always @(negedge sck) begin
        si <= tx_byte[cnt];
    end

    // external clock only within a frame, idles high
    always begin
        wait (ext_go);
        repeat (8) begin
            #80 sck_ext = 1'b0;
            #80 sck_ext = 1'b1;
        end
        wait (!ext_go);
    end
endmodule : shift_partner

`default_nettype wire

/* sync_serial_sio_control_test.sv */
// bench for the serial shift block: register map, transfers, abort, external clock
// assumes the design package, the design and the shift partner are compiled first
`default_nettype none
`timescale 1ns/1ps

module sync_serial_sio_control_test;
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic [31:0] RDATA;
    logic        SCK_O, SCK_OE, SO, SI, IRQ, sck_ext, pin;
    logic        ext_go = 1'b0;
    logic [7:0]  p_tx = 8'h00;
    logic [7:0]  p_rx;
    logic [31:0] v;
    logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h0c, 8'h08, 8'h10, 8'h14, 8'h18};
    logic [31:0] re[7] = '{32'h0, 32'h9, 32'hf3, 32'h0, 32'h0, 32'h0, 32'h0};
    int          err_total = 0;
    int          tests_run = 0;
    int          seed = 32'h4128;
    int          exp_q[$];

    always #2.5 CLK = ~CLK;

    // clock pin level: design drives it only while its enable is high
    assign pin = (SCK_OE === 1'b1) ? SCK_O : sck_ext; // unknown enable counts as released

    sync_serial_sio u_dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .SCK_I(pin), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .SO(SO),
        .SI(SI), .IRQ(IRQ));
    shift_partner u_far (.sck(pin), .so(SO), .ext_go(ext_go), .tx_byte(p_tx), .si(SI),
        .sck_ext(sck_ext), .rx_byte(p_rx));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // one idle cycle after each strobe so no signal is assigned twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
        @(posedge CLK);
    endtask : rd

    // poll status until masked bits match, bounded
    task automatic poll(input logic [31:0] m, input logic [31:0] val);
        logic [31:0] s;
        int n;
        for (n = 0; n < 400; n++) begin
            rd(sio_pkg::OFF_MODE, s);
            if ((s & m) === val) break;
        end
        if (n == 400) begin
            chk("status wait", s & m, val);
            conclude();
        end
    endtask : poll

    // one byte frame in the given direction and clock selection
    task automatic xfer(input logic [1:0] dir, input logic [2:0] sck);
        logic [7:0]  d;
        logic [31:0] ctl, bits, s;
        d = 8'($random(seed));
        p_tx = 8'($random(seed));
        ctl = {26'h0, dir, 1'b0, sck};
        bits = {30'h0, dir != sio_pkg::DIR_TX, dir != sio_pkg::DIR_RX};
        wr(sio_pkg::OFF_XFER, ctl | 32'h40);
        if (dir != sio_pkg::DIR_RX) begin
            wr(sio_pkg::OFF_DATA, {24'h0, d});
            exp_q.push_back(int'(d));
        end
        wr(sio_pkg::OFF_XFER, ctl | 32'h80);
        ext_go <= (sck == sio_pkg::SCK_EXT);
        poll(32'h4, 32'h4);
        chk("clock drive", {31'h0, SCK_OE}, {31'h0, sck != sio_pkg::SCK_EXT});
        wr(sio_pkg::OFF_XFER, ctl);
        poll(32'h8, 32'h0);
        ext_go <= 1'b0;
        // park inhibited so the next setup may change the mode
        wr(sio_pkg::OFF_XFER, ctl | 32'h40);
        if (dir != sio_pkg::DIR_RX) begin
            chk("far byte", {24'h0, p_rx}, {24'h0, 8'(exp_q.pop_front())});
        end
        if (dir != sio_pkg::DIR_TX) begin
            rd(sio_pkg::OFF_DATA, s);
            chk("rx byte", s, {24'h0, p_tx});
        end
        chk("irq pin", {31'h0, IRQ}, 32'h1);
        rd(sio_pkg::OFF_IRQ_ST, s);
        chk("irq source", s, bits);
        #1 chk("irq cleared", {31'h0, IRQ}, 32'h0);
    endtask : xfer

    initial begin
        logic [31:0] c;
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        // reset pattern and fixed bits, unmapped read
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], v);
            chk("reset value", v, re[i]);
        end
        wr(sio_pkg::OFF_XFER, 32'h47);
        rd(sio_pkg::OFF_XFER, v);
        chk("disabled write", v, 32'h9);
        wr(sio_pkg::OFF_ENABLE, 32'hffffffff);
        rd(sio_pkg::OFF_ENABLE, v);
        chk("enable", v, 32'h80);
        for (int m = 0; m < 3; m++) begin
            c = (m == 2) ? 32'h1 : 32'(m * 2);
            wr(sio_pkg::OFF_MODE, c << 2);
            rd(sio_pkg::OFF_XFER, v);
            chk("clock low bit", v, (c == 32'h1) ? 32'h8 : 32'h9);
        end
        rd(sio_pkg::OFF_MODE, v);
        chk("shared address", v, 32'hf3);
        // settings read back and survive disable
        c = 32'h40 | (32'($random(seed)) & 32'h37);
        c[5] = c[5] | c[4]; // keep clear of the reserved direction code
        wr(sio_pkg::OFF_XFER, c);
        wr(sio_pkg::OFF_ENABLE, 32'h0);
        wr(sio_pkg::OFF_XFER, 32'h0);
        rd(sio_pkg::OFF_XFER, v);
        chk("kept setting", v, c | 32'h8);
        wr(sio_pkg::OFF_ENABLE, 32'h80);
        wr(sio_pkg::OFF_IRQ_MSK, 32'h3);
        rd(sio_pkg::OFF_IRQ_MSK, v);
        chk("mask", v, 32'h3);
        xfer(sio_pkg::DIR_TX, 3'h2);
        xfer(sio_pkg::DIR_TRX, 3'h1);
        xfer(sio_pkg::DIR_RX, 3'h2);
        xfer(sio_pkg::DIR_TRX, sio_pkg::SCK_EXT);
        // new setup while stopped and inhibited
        wr(sio_pkg::OFF_XFER, 32'h42);
        wr(sio_pkg::OFF_DATA, 32'h5a);
        rd(sio_pkg::OFF_DATA, v);
        chk("read side", v, {24'h0, p_tx});
        wr(sio_pkg::OFF_XFER, 32'h82);
        poll(32'h4, 32'h4);
        wr(sio_pkg::OFF_XFER, 32'hc2);
        rd(sio_pkg::OFF_MODE, v);
        chk("abort status", v, 32'hf3);
        rd(sio_pkg::OFF_XFER, v);
        chk("abort start", v, 32'h4a);
        conclude();
    end

    // hang guard
    initial begin
        #200000;
        chk("run time", 32'h0, 32'h1);
        conclude();
    end
endmodule : sync_serial_sio_control_test

`default_nettype wire
